// *** hw/psd_params.svh ***
// Purpose: Constants of the paged register address decoder
// Assumes: 8-bit direct address and bit address from the core
// Notes: Every address and page value, and the page selector reset value, live here
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
// Address space
`define PSD_SFR_BASE 8'h80
`define PSD_IRAM_BIT_BASE 8'h20
`define PSD_PAGE_REG_ADDR 8'hA7
`define PSD_BIT_COL_MASK 3'h0

////////////////////////////////////////////////////////////////////////
// Page selector
`define PSD_PAGE_RESET 8'h00
`define PSD_PAGE_ZERO 8'h00
`define PSD_PAGE_F 8'h0F

////////////////////////////////////////////////////////////////////////
// Common registers, decoded on every page
`define PSD_ADR_P0 8'h80
`define PSD_ADR_SP 8'h81
`define PSD_ADR_DPL 8'h82
`define PSD_ADR_DPH 8'h83
`define PSD_ADR_P1 8'h90
`define PSD_ADR_P2 8'hA0
`define PSD_ADR_IE 8'hA8
`define PSD_ADR_CLKSEL 8'hA9
`define PSD_ADR_PSW 8'hD0
`define PSD_ADR_ACC 8'hE0
`define PSD_ADR_EIE1 8'hE6
`define PSD_ADR_EIE2 8'hE7
`define PSD_ADR_B 8'hF0

////////////////////////////////////////////////////////////////////////
// Holes on page zero
`define PSD_HOLE0_A 8'hB4
`define PSD_HOLE0_B 8'hE5

////////////////////////////////////////////////////////////////////////
// Registers that exist only on page 0xF
`define PSD_PF_TOFFL 8'h85
`define PSD_PF_TOFFH 8'h86
`define PSD_PF_CRC_DAT 8'h91
`define PSD_PF_CRC_CN 8'h92
`define PSD_PF_CRC_IN 8'h93
`define PSD_PF_CRC_FLIP 8'h95
`define PSD_PF_CRC_AUTO 8'h96
`define PSD_PF_CRC_CNT 8'h97
`define PSD_PF_P0DRV 8'hA4
`define PSD_PF_P1DRV 8'hA5
`define PSD_PF_P2DRV 8'hA6
`define PSD_PF_ADC_PWR 8'hBA
`define PSD_PF_ADC_TK 8'hBD

`endif

// *** hw/psd_pkg.sv ***
// Purpose: Types of the paged register address decoder
// Assumes: Nothing
// Notes: Constants are in psd_params.svh
package psd_pkg;

   // Which physical bank a decoded register address lands in
   typedef enum logic [1:0]
   {
      PSD_KIND_COMMON = 2'h0,
      PSD_KIND_PAGE0 = 2'h1,
      PSD_KIND_PAGEF = 2'h3,
      PSD_KIND_RESERVED = 2'h2
   } psd_kind_e;

   typedef logic [7:0] psd_addr_t;

endpackage : psd_pkg

// *** hw/psd_map_lookup.sv ***
// Purpose: Classify a register address under the current page
// Assumes: Address already known to be in the upper half
// Notes: Purely combinational
`include "psd_params.svh"

module psd_map_lookup
(
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_page,
   output psd_pkg::psd_kind_e o_kind
);

   ////////////////////////////////////////////////////////////////////
   // Membership functions

   function automatic logic is_common(input logic [7:0] a);
      is_common = (a == `PSD_ADR_P0) || (a == `PSD_ADR_SP) ||
         (a == `PSD_ADR_DPL) || (a == `PSD_ADR_DPH) ||
         (a == `PSD_ADR_P1) || (a == `PSD_ADR_P2) ||
         (a == `PSD_ADR_IE) || (a == `PSD_ADR_CLKSEL) ||
         (a == `PSD_ADR_PSW) || (a == `PSD_ADR_ACC) ||
         (a == `PSD_ADR_EIE1) || (a == `PSD_ADR_EIE2) ||
         (a == `PSD_ADR_B) || (a == `PSD_PAGE_REG_ADDR);
   endfunction : is_common

   function automatic logic is_page0_hole(input logic [7:0] a);
      is_page0_hole = (a == `PSD_HOLE0_A) || (a == `PSD_HOLE0_B);
   endfunction : is_page0_hole

   function automatic logic is_pagef(input logic [7:0] a);
      is_pagef = (a == `PSD_PF_TOFFL) || (a == `PSD_PF_TOFFH) ||
         (a == `PSD_PF_CRC_DAT) || (a == `PSD_PF_CRC_CN) ||
         (a == `PSD_PF_CRC_IN) || (a == `PSD_PF_CRC_FLIP) ||
         (a == `PSD_PF_CRC_AUTO) || (a == `PSD_PF_CRC_CNT) ||
         (a == `PSD_PF_P0DRV) || (a == `PSD_PF_P1DRV) ||
         (a == `PSD_PF_P2DRV) || (a == `PSD_PF_ADC_PWR) ||
         (a == `PSD_PF_ADC_TK);
   endfunction : is_pagef

   ////////////////////////////////////////////////////////////////////
   // Selection

   wire logic common_hit;
   wire logic page0_sel;
   wire logic pagef_sel;

   assign common_hit = is_common(i_addr);
   assign page0_sel = (i_page == `PSD_PAGE_ZERO);
   assign pagef_sel = (i_page == `PSD_PAGE_F);

   assign o_kind =
      common_hit ? psd_pkg::PSD_KIND_COMMON :
      (page0_sel && !is_page0_hole(i_addr)) ? psd_pkg::PSD_KIND_PAGE0 :
      (pagef_sel && is_pagef(i_addr)) ? psd_pkg::PSD_KIND_PAGEF :
      psd_pkg::PSD_KIND_RESERVED;

endmodule : psd_map_lookup

// *** hw/psd_decoder.sv ***
// Purpose: Paged special register address decoder with page selector
// Assumes: Core presents one direct or bit access per valid cycle
// Notes: All decode results appear one clock after the request
//
// Summary of operation
// - Direct accesses to 0x80..0xFF go to register space, not RAM.
// - Addresses ending in 0x0 or 0x8 take bit and byte accesses.
// - Other addresses take only byte accesses; no bit lands there.
// - The page selector resets to zero so page 0x0 is targeted.
// - An 8-bit read/write page register picks the page used.
// - The page register sits at 0xA7 and decodes on every page.
// - Common registers decode the same whatever the page.
// - One address reaches different registers on different pages.
// - Page-0xF-only registers are reached only with page 0xF set.
`include "psd_params.svh"

module psd_decoder
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_acc_valid,
   input wire logic i_acc_write,
   input wire logic i_acc_bit,
   input wire logic [7:0] i_acc_addr,
   input wire logic [7:0] i_acc_wdata,
   output logic o_iram_sel,
   output logic [7:0] o_iram_addr,
   output logic o_sfr_sel,
   output psd_pkg::psd_kind_e o_sfr_kind,
   output logic [7:0] o_sfr_addr,
   output logic o_bit_sel,
   output logic [2:0] o_bit_index,
   output logic o_write,
   output logic [7:0] o_wdata,
   output logic o_reserved,
   output logic o_own_rdata_valid,
   output logic [7:0] o_own_rdata,
   output logic [7:0] o_register_page_select
);

   ////////////////////////////////////////////////////////////////////
   // Address formation

   wire logic upper_half;
   wire logic [7:0] byte_addr;
   wire logic [7:0] iram_bit_addr;
   wire logic sfr_hit;
   wire logic iram_hit;

   assign upper_half = i_acc_addr[7];
   // Bit address: byte register with low three bits cleared
   assign byte_addr = i_acc_bit ?
      {i_acc_addr[7:3], `PSD_BIT_COL_MASK} : i_acc_addr;
   assign iram_bit_addr = `PSD_IRAM_BIT_BASE + {4'h0, i_acc_addr[6:3]};
   assign sfr_hit = i_acc_valid && upper_half;
   assign iram_hit = i_acc_valid && !upper_half;

   ////////////////////////////////////////////////////////////////////
   // Page lookup

   logic [7:0] page_q;
   logic [7:0] page_d;
   psd_pkg::psd_kind_e kind;

   psd_map_lookup psd_map_lookup_i
   (
      .i_addr(byte_addr),
      .i_page(page_q),
      .o_kind(kind)
   );

   wire logic page_reg_hit;
   wire logic page_wr;
   wire logic rsv_hit;
   wire logic live_wr;

   assign page_reg_hit = sfr_hit &&
      (byte_addr == `PSD_PAGE_REG_ADDR);
   assign page_wr = page_reg_hit && i_acc_write && !i_acc_bit;
   assign rsv_hit = sfr_hit && (kind == psd_pkg::PSD_KIND_RESERVED);
   assign live_wr = i_acc_valid && i_acc_write && !rsv_hit;
   assign page_d = page_wr ? i_acc_wdata : page_q;

   ////////////////////////////////////////////////////////////////////
   // Page selector

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         page_q <= `PSD_PAGE_RESET;
      end
      else
      begin
         page_q <= page_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next values of the registered outputs

   wire logic [7:0] iram_addr_d;
   wire logic sfr_sel_d;
   wire logic bit_sel_d;
   wire logic [2:0] bit_index_d;
   wire logic write_d;

   // Bit accesses below register space land in the bit-addressable RAM
   assign iram_addr_d = i_acc_bit ? iram_bit_addr : i_acc_addr;
   assign sfr_sel_d = sfr_hit && !rsv_hit;
   assign bit_sel_d = i_acc_valid && i_acc_bit;
   assign bit_index_d = i_acc_addr[2:0];
   assign write_d = live_wr;

   ////////////////////////////////////////////////////////////////////
   // Route selects

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_iram_sel <= 1'b0;
         o_sfr_sel <= 1'b0;
         o_reserved <= 1'b0;
      end
      else
      begin
         o_iram_sel <= iram_hit;
         o_sfr_sel <= sfr_sel_d;
         o_reserved <= rsv_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register address and kind

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_iram_addr <= 8'h00;
         o_sfr_kind <= psd_pkg::PSD_KIND_RESERVED;
         o_sfr_addr <= 8'h00;
      end
      else
      begin
         o_iram_addr <= iram_addr_d;
         o_sfr_kind <= kind;
         o_sfr_addr <= byte_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bit fields

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_bit_sel <= 1'b0;
         o_bit_index <= 3'h0;
      end
      else
      begin
         o_bit_sel <= bit_sel_d;
         o_bit_index <= bit_index_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write path

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_write <= 1'b0;
         o_wdata <= 8'h00;
      end
      else
      begin
         o_write <= write_d;
         o_wdata <= i_acc_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data owned by this block

   wire logic own_rd;
   wire logic [7:0] own_rd_val;

   assign own_rd = i_acc_valid && !i_acc_write &&
      (page_reg_hit || rsv_hit);
   // Page register reads back; reserved reads return zero
   assign own_rd_val = page_reg_hit ? page_q : 8'h00;

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_own_rdata_valid <= 1'b0;
         o_own_rdata <= 8'h00;
      end
      else
      begin
         o_own_rdata_valid <= own_rd;
         o_own_rdata <= own_rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outside copy of the page selector, one edge after each write

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_register_page_select <= `PSD_PAGE_RESET;
      end
      else
      begin
         o_register_page_select <= page_d;
      end
   end

endmodule : psd_decoder

// *** dv/psd_decoder_asserts.sv ***
// Purpose: Port assertions for the paged register decoder
// Assumes: One clock domain, async reset
// Notes: Bound to psd_decoder after the module
module psd_decoder_asserts
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_acc_valid,
   input wire logic i_acc_write,
   input wire logic i_acc_bit,
   input wire logic [7:0] i_acc_addr,
   input wire logic [7:0] i_acc_wdata,
   input wire logic o_iram_sel,
   input wire logic o_sfr_sel,
   input wire psd_pkg::psd_kind_e o_sfr_kind,
   input wire logic [7:0] o_sfr_addr,
   input wire logic o_bit_sel,
   input wire logic [2:0] o_bit_index,
   input wire logic o_write,
   input wire logic o_reserved,
   input wire logic o_own_rdata_valid,
   input wire logic [7:0] o_own_rdata,
   input wire logic [7:0] o_register_page_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   wire byte_req = i_acc_valid && !i_acc_bit;
   wire page_wr = byte_req && i_acc_write && i_acc_addr == 8'hA7;
   wire page_rd = byte_req && !i_acc_write && i_acc_addr == 8'hA7;
   a_ram_route: assert property (
      byte_req && !i_acc_addr[7] |=> o_iram_sel && !o_sfr_sel)
      else $error("low address not sent to ram");
   a_bit_split: assert property (
      i_acc_valid && i_acc_bit && i_acc_addr[7] |=> o_bit_sel &&
      o_sfr_addr == {$past(i_acc_addr[7:3]), 3'h0} &&
      o_bit_index == $past(i_acc_addr[2:0]))
      else $error("bit address split wrong");
   a_page_load: assert property (
      page_wr |=> o_register_page_select == $past(i_acc_wdata))
      else $error("page register not loaded");
   a_page_hold: assert property (
      !page_wr |=> $stable(o_register_page_select))
      else $error("page register changed without write");
   a_page_read: assert property (
      page_rd |=> o_own_rdata_valid && o_own_rdata == o_register_page_select)
      else $error("page register read wrong");
   a_common_kind: assert property (
      byte_req && i_acc_addr inside {8'h80, 8'hA0, 8'hA7, 8'hD0, 8'hE0}
      |=> o_sfr_sel && o_sfr_kind == psd_pkg::PSD_KIND_COMMON)
      else $error("common register not common");
   a_paged_kind: assert property (
      byte_req && i_acc_addr == 8'hBA |=> o_sfr_kind ==
      ($past(o_register_page_select) == 8'h0F ? psd_pkg::PSD_KIND_PAGEF :
      $past(o_register_page_select) == 8'h00 ? psd_pkg::PSD_KIND_PAGE0 :
      psd_pkg::PSD_KIND_RESERVED))
      else $error("paged address decoded wrong");
   a_hole_quiet: assert property (
      o_reserved |-> !o_write && !o_sfr_sel && (o_own_rdata_valid ==
      !$past(i_acc_write)) && o_own_rdata == 8'h00)
      else $error("reserved access not refused");
endmodule : psd_decoder_asserts

bind psd_decoder psd_decoder_asserts psd_decoder_asserts_i
(
   .i_mclk(i_mclk), .i_rst(i_rst), .i_acc_valid(i_acc_valid),
   .i_acc_write(i_acc_write), .i_acc_bit(i_acc_bit),
   .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata),
   .o_iram_sel(o_iram_sel), .o_sfr_sel(o_sfr_sel),
   .o_sfr_kind(o_sfr_kind), .o_sfr_addr(o_sfr_addr),
   .o_bit_sel(o_bit_sel), .o_bit_index(o_bit_index), .o_write(o_write),
   .o_reserved(o_reserved), .o_own_rdata_valid(o_own_rdata_valid),
   .o_own_rdata(o_own_rdata),
   .o_register_page_select(o_register_page_select)
);

// *** dv/psd_core_model.sv ***
// Purpose: Core side that issues direct and bit accesses
// Assumes: Decoder samples on the rising edge
// Notes: Idle address and data show the inverse of the last value
module psd_core_model
(
   input wire logic i_mclk,
   output logic o_valid,
   output logic o_write,
   output logic o_bit,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_bit = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // One request, held over one rising edge
   task access(input logic [1:0] m, input logic [7:0] a, d);
      @(negedge i_mclk);
      o_valid = 1'b1;
      o_write = m[1];
      o_bit = m[0];
      o_addr = a;
      o_wdata = d;
      @(negedge i_mclk);
      o_valid = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : access
endmodule : psd_core_model

// *** dv/psd_decoder_bench.sv ***
// Purpose: Self-checking bench for the paged register decoder
// Assumes: Decode results one clock after the request
// Notes: Result code is sfr, reserved, ram select and kind
module psd_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic v, w, b, o_iram_sel, o_sfr_sel, o_bit_sel, o_write, o_reserved;
   logic [7:0] a, d, o_iram_addr, o_sfr_addr, o_own_rdata, pg, wd;
   logic [2:0] o_bit_index;
   logic o_own_rdata_valid;
   psd_pkg::psd_kind_e o_sfr_kind;
   int fail_count = 0;
   int n_checks = 0;
   always #5 i_mclk = ~i_mclk;
   psd_core_model psd_core_model_i
   (
      .i_mclk(i_mclk), .o_valid(v), .o_write(w), .o_bit(b), .o_addr(a),
      .o_wdata(d)
   );
   psd_decoder psd_decoder_i
   (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_acc_valid(v), .i_acc_write(w),
      .i_acc_bit(b), .i_acc_addr(a), .i_acc_wdata(d),
      .o_iram_sel(o_iram_sel), .o_iram_addr(o_iram_addr),
      .o_sfr_sel(o_sfr_sel), .o_sfr_kind(o_sfr_kind),
      .o_sfr_addr(o_sfr_addr), .o_bit_sel(o_bit_sel),
      .o_bit_index(o_bit_index), .o_write(o_write), .o_wdata(wd),
      .o_reserved(o_reserved), .o_own_rdata_valid(o_own_rdata_valid),
      .o_own_rdata(o_own_rdata), .o_register_page_select(pg)
   );
   task ck(input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : ck
   task acc(input logic [1:0] m, input logic [7:0] ad, dt, e);
      psd_core_model_i.access(m, ad, dt);
      ck({3'h0, o_sfr_sel, o_reserved, o_iram_sel,
         o_iram_sel ? 2'h0 : 2'(o_sfr_kind)}, e);
   endtask : acc
   task results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   initial
   begin
      #200000;
      fail_count++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst = 1'b0;
      ck(pg, 8'h00);
      acc(2'h0, 8'h7F, 8'h00, 8'h04);
      acc(2'h0, 8'h80, 8'h00, 8'h10);
      acc(2'h0, 8'hBA, 8'h00, 8'h11);
      acc(2'h0, 8'h85, 8'h00, 8'h11);
      acc(2'h0, 8'hB4, 8'h00, 8'h0A);
      ck(o_own_rdata, 8'h00);
      ck({7'h0, o_own_rdata_valid}, 8'h01);
      acc(2'h1, 8'h8B, 8'h00, 8'h11);
      ck(o_sfr_addr, 8'h88);
      ck({4'h0, o_bit_sel, o_bit_index}, 8'h0B);
      acc(2'h1, 8'h13, 8'h00, 8'h04);
      ck(o_iram_addr, 8'h22);
      $display("test page zero done");
      acc(2'h0, 8'hA8, 8'h00, 8'h10);
      acc(2'h2, 8'hA8, 8'h00, 8'h10);
      acc(2'h2, 8'hA7, 8'h0F, 8'h10);
      ck({7'h0, o_write}, 8'h01);
      ck(wd, 8'h0F);
      ck(pg, 8'h0F);
      acc(2'h0, 8'hBA, 8'h00, 8'h13);
      acc(2'h0, 8'hBD, 8'h00, 8'h13);
      acc(2'h0, 8'hB4, 8'h00, 8'h0A);
      acc(2'h0, 8'hA7, 8'h00, 8'h10);
      ck(o_own_rdata, 8'h0F);
      ck({7'h0, o_own_rdata_valid}, 8'h01);
      acc(2'h3, 8'hA7, 8'h00, 8'h10);
      ck(pg, 8'h0F);
      $display("test page f done");
      acc(2'h2, 8'hA7, 8'h05, 8'h10);
      acc(2'h2, 8'hBA, 8'h55, 8'h0A);
      ck({7'h0, o_write}, 8'h00);
      acc(2'h0, 8'hE0, 8'h00, 8'h10);
      i_rst = 1'b1;
      @(negedge i_mclk);
      i_rst = 1'b0;
      ck(pg, 8'h00);
      acc(2'h2, 8'hA8, 8'h80, 8'h10);
      acc(2'h0, 8'hBA, 8'h00, 8'h11);
      $display("test other pages done");
      results();
   end
endmodule : psd_decoder_bench
